// >>> rtl/dcsr_cause_capture.v
// Cause and context capture on debug exceptions and on exceptions
// taken while already in debug mode.
// Assumes the two exception strobes are one-cycle pulses.
`timescale 1ns/10ps
`include "dcsr_regs.vh"

module dcsr_cause_capture (
  input  wire                     i_mclk,
  input  wire                     i_nrst,
  input  wire                     i_dbg_exc,
  input  wire                     i_dm_exc,
  input  wire [`DCSR_NCAUSE-1:0]  i_cause,
  input  wire                     i_delay_slot,
  input  wire                     i_low_power,
  input  wire                     i_bus_clk_run,
  input  wire [`DCSR_EXC_W-1:0]   i_exc_code,
  output reg  [`DCSR_NCAUSE-1:0]  o_cause,
  output reg                      o_delay_slot,
  output reg                      o_doze,
  output reg                      o_halt,
  output reg  [`DCSR_EXC_W-1:0]   o_exc_code
);

  // =====================================================================
  // Capture
  // =====================================================================
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_cause      <= `DCSR_RST_CAUSE;
      o_delay_slot <= `DCSR_RST_BIT;
      o_doze       <= `DCSR_RST_BIT;
      o_halt       <= `DCSR_RST_BIT;
      o_exc_code   <= `DCSR_RST_EXC;
    end else if (i_dm_exc) begin
      o_cause      <= `DCSR_RST_CAUSE;
      o_delay_slot <= i_delay_slot;
      o_exc_code   <= i_exc_code;
    end else if (i_dbg_exc) begin
      o_cause      <= i_cause;
      o_delay_slot <= i_delay_slot;
      o_doze       <= i_low_power;
      o_halt       <= i_bus_clk_run;
    end
  end

endmodule

// >>> rtl/dcsr_pending.v
// Sticky pending flags for imprecise errors, one per generate slot.
// Assumes synchronous set and clear strobes from the same clock domain.
`timescale 1ns/10ps
`include "dcsr_regs.vh"

module dcsr_pending (
  input  wire                     i_mclk,
  input  wire                     i_nrst,
  input  wire [`DCSR_NPEND-1:0]   i_hw_set,
  input  wire [`DCSR_NPEND-1:0]   i_sw_set,
  input  wire [`DCSR_NPEND-1:0]   i_clear,
  output wire [`DCSR_NPEND-1:0]   o_pend
);

  reg [`DCSR_NPEND-1:0] pend;

  // =====================================================================
  // Flags
  // =====================================================================
  // A set in the same cycle as a clear wins, so no error is lost.
  genvar g;
  generate
    for (g = 0; g < `DCSR_NPEND; g = g + 1) begin : g_flag
      always @(posedge i_mclk) begin
        if (!i_nrst) begin
          pend[g] <= 1'h0;
        end else if (i_hw_set[g] || i_sw_set[g]) begin
          pend[g] <= 1'h1;
        end else if (i_clear[g]) begin
          pend[g] <= 1'h0;
        end
      end
    end
  endgenerate

  assign o_pend = pend;

endmodule

// >>> rtl/dcsr_regs.vh
// Bit positions, field widths and reset values of the debug control
// and status register.
// Assumes it is included by the register logic and its helpers.
`ifndef DCSR_REGS_VH
`define DCSR_REGS_VH

// =====================================================================
// Field positions
// =====================================================================
`define DCSR_DELAY_SLOT     31
`define DCSR_IN_DEBUG       30
`define DCSR_NO_SEGMENT     29
`define DCSR_REDIRECT       28
`define DCSR_DOZE           27
`define DCSR_HALT           26
`define DCSR_TIMER_RUNS     25
`define DCSR_FETCH_PEND     24
`define DCSR_MCHECK_PEND    23
`define DCSR_CACHE_PEND     22
`define DCSR_DATA_PEND      21
`define DCSR_INHIBIT        20
`define DCSR_IMPR_STORE     19
`define DCSR_IMPR_LOAD      18
`define DCSR_VER_HI         17
`define DCSR_VER_LO         15
`define DCSR_EXC_HI         14
`define DCSR_EXC_LO         10
`define DCSR_SS_ABSENT      9
`define DCSR_SS_ENABLE      8
`define DCSR_RSVD7          7
`define DCSR_IMPR_INSTR     6
`define DCSR_DBG_INT        5
`define DCSR_INSTR_BREAK    4
`define DCSR_STORE_BREAK    3
`define DCSR_LOAD_BREAK     2
`define DCSR_SW_BP          1
`define DCSR_SINGLE_STEP    0

// =====================================================================
// Widths and reset values
// =====================================================================
`define DCSR_NCAUSE         9
`define DCSR_NPEND          3
`define DCSR_EXC_W          5
`define DCSR_VERSION        3'h0
`define DCSR_NO_SEG_VAL     1'h0
`define DCSR_SS_ABSENT_VAL  1'h0
`define DCSR_RST_TIMER      1'h1
`define DCSR_RST_BIT        1'h0
`define DCSR_RST_EXC        5'h00
`define DCSR_RST_CAUSE      9'h000
`define DCSR_RST_PEND       3'h0

`endif

// >>> rtl/dcsr_top.v
// Debug control and status register of the system-control coprocessor.
// Assumes coprocessor moves and exception strobes come from the core
// pipeline as one-cycle pulses on i_mclk.
//
// Function
// - Outside debug mode only the debug flag and version read defined.
// - Break, step and interrupt causes load on debug exceptions, clear on debug-mode ones.
// - Nested exception code written only on exceptions in debug mode.
// - Low power and bus clock state captured on debug exceptions.
// - Bit 31 records a delay or forbidden slot of the latest exception.
// - Bit 30 reads one in debug mode, zero otherwise, resets low.
// - Bit 29 reads zero: the debug segment is present.
// - Bit 28 sends segment loads and stores to main memory when set.
// - Bit 25 keeps the timer running in debug mode, resets high.
// - Fetch bus error pending set by error or write, cleared when taken.
// - Bit 22 flags a pending imprecise cache error, writable with one.
// - Bit 21 flags a pending data bus error, writable with one.
// - Inhibit set on entry, cleared by debug return, defers errors.
// - Bit 8 enables single step; bit 9 reads zero as it is present.
// - Bit 5 marks a debug interrupt, cleared on debug-mode exception.
// - Bit 4 marks an instruction break, cleared on debug-mode exception.
// - Bits 3 and 2 mark store and load data breaks.
// - Bit 1 marks a software breakpoint, cleared on debug-mode exception.
// - Bit 0 marks single step, cleared on debug-mode exception.
// - Bit 6 marks an imprecise instruction break from complex breaks.
// - Bits 19 and 18 mark imprecise store and load data breaks.
// - A one in the single-step cause bit means a step exception.
`timescale 1ns/10ps
`include "dcsr_regs.vh"

module dcsr_top (
  input  wire                     i_mclk,
  input  wire                     i_nrst,
  // Coprocessor moves.
  input  wire                     i_mtc0,
  input  wire [31:0]              i_wdata,
  input  wire                     i_mfc0,
  output reg  [31:0]              o_rdata,
  // Debug exception and its cause.
  input  wire                     i_dbg_exc,
  input  wire                     i_cause_single_step,
  input  wire                     i_cause_sw_bp,
  input  wire                     i_cause_load_break,
  input  wire                     i_cause_store_break,
  input  wire                     i_cause_instr_break,
  input  wire                     i_cause_dbg_int,
  input  wire                     i_cause_impr_instr,
  input  wire                     i_cause_impr_load,
  input  wire                     i_cause_impr_store,
  input  wire                     i_delay_slot,
  input  wire                     i_low_power,
  input  wire                     i_bus_clk_run,
  // Exception taken in debug mode.
  input  wire                     i_dm_exc,
  input  wire [`DCSR_EXC_W-1:0]   i_exc_code,
  // Debug return instruction retired.
  input  wire                     i_debug_return_instr,
  // Imprecise error events and their acceptance by the core.
  input  wire                     i_fetch_buserr,
  input  wire                     i_data_buserr,
  input  wire                     i_cache_err,
  input  wire                     i_data_buserr_taken,
  input  wire                     i_cache_err_taken,
  // Control outputs.
  output reg                      o_in_debug_flag,
  output reg                      o_segment_access_redirect,
  output reg                      o_timer_run,
  output reg                      o_single_step_enable,
  output reg                      o_imprecise_error_inhibit,
  output reg                      o_fetch_buserr_take,
  output reg                      o_impr_err_req
);

  // =====================================================================
  // State
  // =====================================================================
  reg                       in_debug_flag;
  reg                       segment_access_redirect;
  reg                       timer_runs_in_debug;
  reg                       single_step_enable;
  reg                       imprecise_error_inhibit;
  reg                       next_in_debug;
  reg                       next_inhibit;
  wire                      wr_ok;
  wire                      entry;
  wire [`DCSR_NCAUSE-1:0]   cause_in;
  wire [`DCSR_NCAUSE-1:0]   cause;
  wire                      delay_slot_flag;
  wire                      doze_flag;
  wire                      halt_flag;
  wire [`DCSR_EXC_W-1:0]    nested_exception_code;
  wire [`DCSR_NPEND-1:0]    pend;
  wire [`DCSR_NPEND-1:0]    hw_set;
  wire [`DCSR_NPEND-1:0]    sw_set;
  wire [`DCSR_NPEND-1:0]    pend_clear;
  wire                      fetch_buserr_pending;
  wire                      data_buserr_pending;
  wire                      cache_error_pending;
  wire [31:0]               full_view;

  // =====================================================================
  // Helpers
  // =====================================================================
  // Returns one when an accepted write carries a one at the given bit.
  function wr_one;
    input        ok;
    input [31:0] d;
    input integer pos;
    begin
      wr_one = ok & d[pos];
    end
  endfunction

  // Writes made outside debug mode are dropped rather than left undefined.
  assign wr_ok = i_mtc0 & in_debug_flag;
  assign entry = i_dbg_exc | i_dm_exc;

  // =====================================================================
  // Debug mode and inhibit
  // =====================================================================
  // Entry wins over a return in the same cycle.
  always @* begin
    next_in_debug = in_debug_flag;
    next_inhibit  = imprecise_error_inhibit;
    if (entry) begin
      next_in_debug = 1'h1;
      next_inhibit  = 1'h1;
    end else if (i_debug_return_instr) begin
      next_in_debug = 1'h0;
      next_inhibit  = 1'h0;
    end else if (wr_ok) begin
      next_inhibit  = wr_one(1'h1, i_wdata, `DCSR_INHIBIT);
    end
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      in_debug_flag           <= `DCSR_RST_BIT;
      imprecise_error_inhibit <= `DCSR_RST_BIT;
    end else begin
      in_debug_flag           <= next_in_debug;
      imprecise_error_inhibit <= next_inhibit;
    end
  end

  // =====================================================================
  // Software control bits
  // =====================================================================
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      segment_access_redirect <= `DCSR_RST_BIT;
      timer_runs_in_debug     <= `DCSR_RST_TIMER;
      single_step_enable      <= `DCSR_RST_BIT;
    end else if (wr_ok) begin
      segment_access_redirect <= wr_one(1'h1, i_wdata, `DCSR_REDIRECT);
      timer_runs_in_debug     <= wr_one(1'h1, i_wdata, `DCSR_TIMER_RUNS);
      single_step_enable      <= wr_one(1'h1, i_wdata, `DCSR_SS_ENABLE);
    end
  end

  // =====================================================================
  // Imprecise error pending flags
  // =====================================================================
  // Slot 0 fetch bus error, slot 1 data bus error, slot 2 cache error.
  assign hw_set = {i_cache_err, i_data_buserr, i_fetch_buserr};
  assign sw_set = {wr_one(wr_ok, i_wdata, `DCSR_CACHE_PEND),
                   wr_one(wr_ok, i_wdata, `DCSR_DATA_PEND),
                   wr_one(wr_ok, i_wdata, `DCSR_FETCH_PEND)};
  assign pend_clear = {i_cache_err_taken, i_data_buserr_taken, o_fetch_buserr_take};

  dcsr_pending u_pending (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_hw_set (hw_set),
    .i_sw_set (sw_set),
    .i_clear  (pend_clear),
    .o_pend   (pend)
  );

  assign fetch_buserr_pending = pend[0];
  assign data_buserr_pending  = pend[1];
  assign cache_error_pending  = pend[2];

  // The fetch error is taken with a one-cycle pulse once inhibit is low;
  // the pending flag drops at the edge that ends the pulse.
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_fetch_buserr_take <= 1'h0;
      o_impr_err_req      <= 1'h0;
    end else begin
      o_fetch_buserr_take <= fetch_buserr_pending & ~next_inhibit
                             & ~o_fetch_buserr_take;
      o_impr_err_req      <= (data_buserr_pending | cache_error_pending)
                             & ~next_inhibit;
    end
  end

  // =====================================================================
  // Cause capture
  // =====================================================================
  assign cause_in = {i_cause_impr_store,
                     i_cause_impr_load,
                     i_cause_impr_instr,
                     i_cause_dbg_int,
                     i_cause_instr_break,
                     i_cause_store_break,
                     i_cause_load_break,
                     i_cause_sw_bp,
                     i_cause_single_step};

  dcsr_cause_capture u_capture (
    .i_mclk        (i_mclk),
    .i_nrst        (i_nrst),
    .i_dbg_exc     (i_dbg_exc),
    .i_dm_exc      (i_dm_exc),
    .i_cause       (cause_in),
    .i_delay_slot  (i_delay_slot),
    .i_low_power   (i_low_power),
    .i_bus_clk_run (i_bus_clk_run),
    .i_exc_code    (i_exc_code),
    .o_cause       (cause),
    .o_delay_slot  (delay_slot_flag),
    .o_doze        (doze_flag),
    .o_halt        (halt_flag),
    .o_exc_code    (nested_exception_code)
  );

  // =====================================================================
  // Read view
  // =====================================================================
  assign full_view = {delay_slot_flag,
                      in_debug_flag,
                      `DCSR_NO_SEG_VAL,
                      segment_access_redirect,
                      doze_flag,
                      halt_flag,
                      timer_runs_in_debug,
                      fetch_buserr_pending,
                      1'h0,
                      cache_error_pending,
                      data_buserr_pending,
                      imprecise_error_inhibit,
                      cause[8],
                      cause[7],
                      `DCSR_VERSION,
                      nested_exception_code,
                      `DCSR_SS_ABSENT_VAL,
                      single_step_enable,
                      1'h0,
                      cause[6:0]};

  // Outside debug mode everything but the mode flag and version reads zero.
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_rdata <= 32'h00000000;
    end else if (i_mfc0) begin
      if (in_debug_flag) begin
        o_rdata <= full_view;
      end else begin
        o_rdata <= {14'h0000, `DCSR_VERSION, 15'h0000};
      end
    end
  end

  // =====================================================================
  // Control outputs
  // =====================================================================
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_in_debug_flag           <= `DCSR_RST_BIT;
      o_segment_access_redirect <= `DCSR_RST_BIT;
      o_timer_run               <= `DCSR_RST_TIMER;
      o_single_step_enable      <= `DCSR_RST_BIT;
      o_imprecise_error_inhibit <= `DCSR_RST_BIT;
    end else begin
      o_in_debug_flag           <= in_debug_flag;
      o_segment_access_redirect <= segment_access_redirect;
      o_timer_run               <= ~in_debug_flag | timer_runs_in_debug;
      o_single_step_enable      <= single_step_enable;
      o_imprecise_error_inhibit <= imprecise_error_inhibit;
    end
  end

endmodule

// >>> verif/dcsr_top_chk.sv
// Concurrent checks on the ports of the debug control and status register.
// Assumes one clock, i_mclk, and the synchronous active-low reset i_nrst.
`timescale 1ns/10ps

module dcsr_chk (
  input wire        i_mclk,
  input wire        i_nrst,
  input wire        i_mtc0,
  input wire [31:0] i_wdata,
  input wire        i_mfc0,
  input wire [31:0] o_rdata,
  input wire        i_dbg_exc,
  input wire        i_dm_exc,
  input wire        i_debug_return_instr,
  input wire        i_fetch_buserr,
  input wire        i_data_buserr,
  input wire        i_cache_err,
  input wire        o_in_debug_flag,
  input wire        o_segment_access_redirect,
  input wire        o_timer_run,
  input wire        o_single_step_enable,
  input wire        o_imprecise_error_inhibit,
  input wire        o_fetch_buserr_take,
  input wire        o_impr_err_req
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // =====================================================================
  // Sequences
  // =====================================================================
  // The control outputs lag the register by one cycle, so the register
  // state at a sampling edge is rebuilt from the output and the last edge.
  sequence s_normal_read;
    i_mfc0 && !o_in_debug_flag && !$past(i_dbg_exc);
  endsequence
  sequence s_debug_write;
    i_mtc0 && o_in_debug_flag && !$past(i_debug_return_instr);
  endsequence
  sequence s_fetch_free;
    i_fetch_buserr ##1 !o_fetch_buserr_take;
  endsequence

  // =====================================================================
  // Assertions
  // =====================================================================
  a_normal_read_zero: assert property (s_normal_read |=> o_rdata == 32'h0)
    else $error("read outside debug mode not zero");
  a_entry_flags: assert property (i_dbg_exc |-> ##2
    (o_in_debug_flag && o_imprecise_error_inhibit))
    else $error("debug entry did not set mode and inhibit");
  a_return_exit: assert property
    (i_debug_return_instr && !i_dbg_exc && !i_dm_exc && !i_mtc0 |-> ##2
    !(o_in_debug_flag || o_imprecise_error_inhibit))
    else $error("debug return did not clear mode and inhibit");
  a_write_fields: assert property (s_debug_write |-> ##2
    (o_segment_access_redirect == $past(i_wdata[28], 2) &&
     o_single_step_enable == $past(i_wdata[8], 2) &&
     o_timer_run == ($past(i_wdata[25], 2) || !o_in_debug_flag)))
    else $error("written control bits not seen on outputs");
  a_timer_normal: assert property (!o_in_debug_flag |-> o_timer_run)
    else $error("timer stopped outside debug mode");
  a_take_single: assert property (o_fetch_buserr_take |=> !o_fetch_buserr_take)
    else $error("fetch error take longer than one cycle");
  a_take_uninhib: assert property (o_fetch_buserr_take |=> !o_imprecise_error_inhibit)
    else $error("fetch error taken while inhibited");
  a_fetch_taken: assert property (s_fetch_free |=>
    (o_fetch_buserr_take or ##1 o_imprecise_error_inhibit))
    else $error("pending fetch error not taken");
  a_req_uninhib: assert property (o_impr_err_req |=> !o_imprecise_error_inhibit)
    else $error("error request while inhibited");
  a_data_err_req: assert property (i_data_buserr |-> ##2
    (o_impr_err_req or ##1 o_imprecise_error_inhibit))
    else $error("data bus error not requested");
  a_cache_err_req: assert property (i_cache_err |-> ##2
    (o_impr_err_req or ##1 o_imprecise_error_inhibit))
    else $error("cache error not requested");
endmodule

bind dcsr_top dcsr_chk u_chk (.*);

// >>> verif/dcsr_top_tb.sv
// Self-checking bench for the debug control and status register.
// Assumes the design answers reads one cycle late and lags outputs a cycle.
`timescale 1ns/10ps

module dcsr_top_tb;
  logic        i_mclk, i_nrst, i_mtc0, i_mfc0, i_dbg_exc, i_dm_exc;
  logic        i_debug_return_instr, i_fetch_buserr, i_data_buserr;
  logic        i_cache_err, i_data_buserr_taken, i_cache_err_taken;
  logic [31:0] i_wdata, m, n, mrd;
  logic [8:0]  cz;
  logic [2:0]  ctx;
  logic [4:0]  i_exc_code;
  logic [5:0]  ex;
  logic        mtk;
  wire  [31:0] o_rdata;
  wire  [6:0]  outs;
  integer      seed, err_count, comparisons, i;

  dcsr_top dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_mtc0(i_mtc0), .i_wdata(i_wdata),
    .i_mfc0(i_mfc0), .o_rdata(o_rdata), .i_dbg_exc(i_dbg_exc),
    .i_cause_single_step(cz[0]), .i_cause_sw_bp(cz[1]), .i_cause_load_break(cz[2]),
    .i_cause_store_break(cz[3]), .i_cause_instr_break(cz[4]),
    .i_cause_dbg_int(cz[5]), .i_cause_impr_instr(cz[6]), .i_cause_impr_load(cz[7]),
    .i_cause_impr_store(cz[8]), .i_delay_slot(ctx[2]), .i_low_power(ctx[1]),
    .i_bus_clk_run(ctx[0]), .i_dm_exc(i_dm_exc), .i_exc_code(i_exc_code),
    .i_debug_return_instr(i_debug_return_instr), .i_fetch_buserr(i_fetch_buserr),
    .i_data_buserr(i_data_buserr), .i_cache_err(i_cache_err),
    .i_data_buserr_taken(i_data_buserr_taken), .i_cache_err_taken(i_cache_err_taken),
    .o_in_debug_flag(outs[1]), .o_segment_access_redirect(outs[2]),
    .o_timer_run(outs[3]), .o_single_step_enable(outs[4]),
    .o_imprecise_error_inhibit(outs[5]), .o_fetch_buserr_take(outs[0]),
    .o_impr_err_req(outs[6])
  );

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // =====================================================================
  // Reference model, stepped on every rising edge
  // =====================================================================
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      m = 32'h0200_0000;
      mrd = 32'h0;
      mtk = 1'b0;
      ex = 6'h04;
    end else begin
      n = m;
      ex = {(m[21] | m[22]) & ~m[20], m[20], m[8], ~m[30] | m[25], m[28], m[30]};
      if (i_mfc0)
        mrd = m[30] ? m : 32'h0;
      if (i_data_buserr_taken) n[21] = 1'b0;
      if (i_cache_err_taken) n[22] = 1'b0;
      if (mtk) n[24] = 1'b0;
      if (i_mtc0 && m[30]) begin
        {n[28], n[25], n[20], n[8]} = {i_wdata[28], i_wdata[25], i_wdata[20], i_wdata[8]};
        // Write-one bits only set; bit 23 stays zero.
        n[24:21] = n[24:21] | (i_wdata[24:21] & 4'hB);
      end
      if (i_dbg_exc) begin
        {n[31], n[27], n[26]} = ctx;
        {n[19:18], n[6:0]} = cz;
      end else if (i_dm_exc) begin
        n[31] = ctx[2];
        n[19:18] = 2'h0;
        n[6:0] = 7'h00;
        n[14:10] = i_exc_code;
      end
      if (i_dbg_exc || i_dm_exc)
        {n[30], n[20]} = 2'h3;
      else if (i_debug_return_instr)
        {n[30], n[20]} = 2'h0;
      n[24] = n[24] | i_fetch_buserr;
      n[22] = n[22] | i_cache_err;
      n[21] = n[21] | i_data_buserr;
      ex[5] = (m[21] | m[22]) & ~n[20];
      mtk = m[24] & ~n[20] & ~mtk;
      m = n;
    end
  end

  // =====================================================================
  // Tasks
  // =====================================================================
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Random legal traffic: exceptions match the mode, no write beside one.
  task drive;
    reg [31:0] r;
    reg [31:0] s;
    begin
      r = $random(seed);
      s = $random(seed);
      i_wdata = $random(seed);
      {cz, ctx, i_exc_code} = s[16:0];
      {i_mtc0, i_dbg_exc, i_dm_exc, i_debug_return_instr} = 4'h0;
      i_mfc0 = r[0];
      case (r[3:1])
        3'h0: begin
          i_dm_exc = m[30];
          i_dbg_exc = ~m[30];
        end
        3'h1: i_debug_return_instr = m[30];
        3'h2, 3'h3: i_mtc0 = m[30];
        default: ;
      endcase
      i_fetch_buserr = (r[6:4] == 3'h0) && !m[24] && !mtk;
      i_data_buserr = r[9:7] == 3'h0;
      i_cache_err = r[12:10] == 3'h0;
      i_data_buserr_taken = r[15:13] == 3'h0;
      i_cache_err_taken = r[18:16] == 3'h0;
    end
  endtask

  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial begin
    seed = 32'h441A18D7;
    err_count = 0;
    comparisons = 0;
    i_nrst = 1'b0;
    {i_mtc0, i_mfc0, i_dbg_exc, i_dm_exc, i_debug_return_instr} = 5'h00;
    {i_fetch_buserr, i_data_buserr, i_cache_err} = 3'h0;
    {i_data_buserr_taken, i_cache_err_taken} = 2'h0;
    {i_wdata, cz, ctx, i_exc_code} = 49'h0;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    i_nrst = 1'b1;
    for (i = 0; i < 4000; i = i + 1) begin
      drive;
      if (i == 2000) i_nrst = 1'b0;
      if (i == 2003) i_nrst = 1'b1;
      @(negedge i_mclk);
      chk(o_rdata, mrd);
      chk({25'h0, outs}, {25'h0, ex, mtk});
    end
    end_of_test;
  end
endmodule
